// ### fbwp_array_model.sv
// array engine model: ends each started operation after a few cycles
// assumes starts are one-cycle pulses on sys_clk
`default_nettype none
module fbwp_array_model (
  input wire logic  sys_clk,
  input wire logic  rst,
  input wire logic  array_op_start,
  output logic      array_op_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_r <= 4'h0;
    end else if (array_op_start) begin
      cnt_r <= 4'h6;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
  assign array_op_done = (cnt_r == 4'h1);
endmodule : fbwp_array_model
`default_nettype wire

// ### fbwp_pkg.sv
// types shared by the flash write-protection block
// assumes fbwp_regs.svh is on the include path
`default_nettype none
package fbwp_pkg;

  typedef enum logic [3:0] {
    FBWP_OP_NONE,
    FBWP_OP_WRITE_LATCH_SET_CMD,
    FBWP_OP_WRDI,
    FBWP_OP_STATUS_WRITE_CMD,
    FBWP_OP_PROG,
    FBWP_OP_ERASE,
    FBWP_OP_CHIP,
    FBWP_OP_VOL_FREE,
    FBWP_OP_VOL_WEL
  } fbwp_op_e;

  typedef struct packed {
    logic       status_write_disable;
    logic       quad_enable;
    logic [3:0] protect_level;
    logic       write_enable_latch;
    logic       busy;
  } fbwp_status_s;

  typedef struct packed {
    logic [7:0] opcode;
    logic       status_lock;
    logic       busy;
    logic       chip_bp;
    logic       prot;
    logic       no_wel;
    logic       accept;
  } fbwp_result_s;

  typedef struct packed {
    logic       start;
    fbwp_op_e   kind;
    logic [31:0] addr;
  } fbwp_array_req_s;

endpackage : fbwp_pkg
`default_nettype wire

// ### fbwp_props.sv
// port-level checker for fbwp_top
// assumes clk_en held high and binding onto fbwp_top
`default_nettype none
module fbwp_props #(
  parameter int ADDR_W = 32
) (
  input wire logic               sys_clk,
  input wire logic               rst,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic               pready,
  input wire logic               array_op_start,
  input wire fbwp_pkg::fbwp_op_e array_op_kind,
  input wire logic [ADDR_W-1:0]  array_op_addr,
  input wire logic               vol_cmd_strobe,
  input wire logic [7:0]         vol_cmd_opcode,
  input wire logic               quad_mode,
  input wire logic               hold_active,
  input wire logic               write_protect_active
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cw;
  // command write completing on this edge
  assign cw = psel && penable && pready && pwrite && paddr == 8'h0c;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_start_cause; array_op_start |-> $past(cw, 2); endproperty
  a_start_cause: assert property (p_start_cause) else $error("start without command");
  property p_start_kind; array_op_start |-> array_op_kind inside {fbwp_pkg::FBWP_OP_PROG,
    fbwp_pkg::FBWP_OP_ERASE, fbwp_pkg::FBWP_OP_CHIP}; endproperty
  a_start_kind: assert property (p_start_kind) else $error("bad start kind");
  property p_chip_addr; array_op_start && array_op_kind == fbwp_pkg::FBWP_OP_CHIP |-> array_op_addr == '0; endproperty
  a_chip_addr: assert property (p_chip_addr) else $error("chip erase address");
  property p_vol_cause; vol_cmd_strobe |-> $past(cw, 2) && !$past(vol_cmd_strobe); endproperty
  a_vol_cause: assert property (p_vol_cause) else $error("volatile strobe cause");
  property p_vol_code; vol_cmd_strobe |-> vol_cmd_opcode inside {8'hc0, 8'h17, 8'h63, 8'hc5}; endproperty
  a_vol_code: assert property (p_vol_code) else $error("volatile opcode");
  property p_quad_cause; $changed(quad_mode) |-> $past(cw, 2) || $past(cw, 3); endproperty
  a_quad_cause: assert property (p_quad_cause) else $error("quad changed alone");
  property p_quad_pins; quad_mode && $past(quad_mode) |-> !hold_active && !write_protect_active; endproperty
  a_quad_pins: assert property (p_quad_pins) else $error("pins active in quad");
  property p_rdy_ws; psel && penable && !pready |=> pready ##1 !pready; endproperty
  a_rdy_ws: assert property (p_rdy_ws) else $error("apb wait state");
endmodule : fbwp_props

bind fbwp_top fbwp_props #(.ADDR_W(ADDR_W)) u_props (
  .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pready, .array_op_start, .array_op_kind,
  .array_op_addr, .vol_cmd_strobe, .vol_cmd_opcode, .quad_mode, .hold_active, .write_protect_active);
`default_nettype wire

// ### fbwp_prot_cmp.sv
// block-protection comparator: is a target address inside the protected area
// assumes level, selector and address are registered by the caller
`default_nettype none
`include "fbwp_regs.svh"
module fbwp_prot_cmp #(
  parameter int ADDR_W = 32
) (
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [3:0]        level,
  input  wire logic              top_bottom_select,
  input  wire logic              big_block,
  output logic                   in_protected
);

  logic [10:0] cnt;
  logic [10:0] total;
  logic [10:0] blk;

  // protected block count for the level
  always_comb begin
    cnt = 11'h000;
    if (big_block) begin
      if (level == 4'h0) begin
        cnt = 11'h000;
      end else if (level <= `FBWP_LVL_POW_256) begin
        cnt = 11'h001 << (level - 4'h1);
      end else begin
        cnt = 11'h100;
      end
    end else begin
      if (level == 4'h0) begin
        cnt = 11'h000;
      end else if (level <= `FBWP_LVL_POW_MAX) begin
        cnt = 11'h001 << (level - 4'h1);
      end else begin
        case (level)
          4'hb:    cnt = `FBWP_CNT_L11;
          4'hc:    cnt = `FBWP_CNT_L12;
          4'hd:    cnt = `FBWP_CNT_L13;
          4'he:    cnt = `FBWP_CNT_L14;
          default: cnt = 11'h400;
        endcase
      end
    end
  end

  always_comb begin
    if (big_block) begin
      total = 11'h100;
      blk   = {3'h0, addr[`FBWP_SHIFT_256K +: 8]};
    end else begin
      total = 11'h400;
      blk   = {1'h0, addr[`FBWP_SHIFT_64K +: 10]};
    end
  end

  // top area ends at the last block, bottom starts at block 0
  always_comb begin
    if (top_bottom_select) begin
      in_protected = (blk < cnt);
    end else begin
      in_protected = (cnt != 11'h000) && (blk >= (total - cnt));
    end
  end

endmodule : fbwp_prot_cmp
`default_nettype wire

// ### fbwp_regs.svh
// register offsets, field positions, opcodes and reset values of the flash write-protection block
// assumes inclusion by bare name from the design files
`ifndef FBWP_REGS_SVH
`define FBWP_REGS_SVH

// apb byte offsets
`define FBWP_OFF_STATUS   8'h00
`define FBWP_OFF_CONFIG   8'h04
`define FBWP_OFF_ADDR     8'h08
`define FBWP_OFF_CMD      8'h0c
`define FBWP_OFF_RESULT   8'h10
`define FBWP_OFF_PINS     8'h14

// status byte layout
`define FBWP_SR_WIP       0
`define FBWP_SR_WEL       1
`define FBWP_SR_LVL_LO    2
`define FBWP_SR_LVL_MID   3
`define FBWP_SR_LVL_HI    4
`define FBWP_SR_LVL3      5
`define FBWP_SR_QE        6
`define FBWP_SR_SWD       7
`define FBWP_SR_RESET     8'h00

// config register bits
`define FBWP_CFG_TBS      0
`define FBWP_CFG_BIG_BLK  1
`define FBWP_CFG_RESET    2'h0

// command register fields
`define FBWP_CMD_OP_LSB   0
`define FBWP_CMD_DAT_LSB  8

// result register fields
`define FBWP_RES_ACCEPT   0
`define FBWP_RES_NO_WEL   1
`define FBWP_RES_PROT     2
`define FBWP_RES_CHIP_BP  3
`define FBWP_RES_SR_LOCK  5
`define FBWP_RES_BUSY     4
`define FBWP_RES_OP_LSB   6

// opcodes
`define FBWP_OPC_STATUS_WRITE_CMD     8'h01
`define FBWP_OPC_WRITE_LATCH_SET_CMD     8'h06
`define FBWP_OPC_WRDI     8'h04
`define FBWP_OPC_PP       8'h02
`define FBWP_OPC_PP4      8'h12
`define FBWP_OPC_PPQ      8'h32
`define FBWP_OPC_PPQ4     8'h34
`define FBWP_OPC_PPQIO    8'h38
`define FBWP_OPC_PPQIO4   8'h3e
`define FBWP_OPC_SE_A     8'h20
`define FBWP_OPC_SE_B     8'hd7
`define FBWP_OPC_SE4      8'h21
`define FBWP_OPC_BE32     8'h52
`define FBWP_OPC_BE32_4   8'h5c
`define FBWP_OPC_BE64     8'hd8
`define FBWP_OPC_BE64_4   8'hdc
`define FBWP_OPC_CE_A     8'hc7
`define FBWP_OPC_CE_B     8'h60
`define FBWP_OPC_RDP_VOL  8'hc0
`define FBWP_OPC_BANK_VOL 8'h17
`define FBWP_OPC_RDP_VOLW 8'h63
`define FBWP_OPC_BANKVOLW 8'hc5

// protection geometry
`define FBWP_SHIFT_64K    16
`define FBWP_SHIFT_256K   18
`define FBWP_LVL_ALL      4'hf
`define FBWP_LVL_POW_MAX  4'ha
`define FBWP_LVL_POW_256  4'h8
`define FBWP_CNT_L11      11'h300
`define FBWP_CNT_L12      11'h380
`define FBWP_CNT_L13      11'h3c0
`define FBWP_CNT_L14      11'h3e0

`endif

// ### fbwp_top.sv
// flash write-protection block: status byte, protect-level decode, command gating, apb slave
// assumes an apb master on sys_clk, asynchronous protect/hold pins, array engine on sys_clk
// Operation
// - volatile read-parameter set c0h and bank write 17h need no write-enable latch
// - program or erase into the protected area is refused, array left untouched
// - whole-chip erase is ignored unless all protect level bits are zero
// - with write-disable bit clear, status writes always work whatever the pin
// - write-disable set and protect pin low: status write ignored, bits read-only
// - write-disable set and protect pin high: status write updates normally
// - quad-enable 0: pins are protect and hold; 1: pins are data lines 2 and 3
// - 64KB blocks: level 0 protects none, levels 1-10 protect 2^(level-1) blocks
// - 64KB blocks: levels 11-14 protect 768, 896, 960, 992; level 15 all 1024
// - selector 0 puts protected blocks at the top, 1 at the bottom from block 0
// - 256KB blocks: levels 1-8 protect 2^(level-1) blocks, top or bottom
// - 256KB blocks: levels 9-15 protect all 256 blocks
// - protect, quad-enable and write-disable bits change only by status write 01h
// - status write, program and erase need the write-enable latch set by 06h
// - quad-enable is status bit 6, write-disable bit 7, both reset to zero
//
// Implementation choices: the APB interface to the registers and the address map.
`default_nettype none
`include "fbwp_regs.svh"
module fbwp_top #(
  parameter int ADDR_W = 32
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // shared pins, asynchronous
  input  wire logic              wp_pin_n,
  input  wire logic              hold_pin_n,
  // array engine
  input  wire logic              array_op_done,
  output logic                   array_op_start,
  output fbwp_pkg::fbwp_op_e     array_op_kind,
  output logic [ADDR_W-1:0]      array_op_addr,
  output logic                   vol_cmd_strobe,
  output logic [7:0]             vol_cmd_opcode,
  output logic                   quad_mode,
  output logic                   hold_active,
  output logic                   write_protect_active
);

  if (ADDR_W < 26 || ADDR_W > 32) begin : g_bad_addr_w
    $error("fbwp_top: ADDR_W must be 26..32");
  end

  typedef enum logic [1:0] {
    FBWP_ST_IDLE,
    FBWP_ST_EVAL,
    FBWP_ST_BUSY
  } fbwp_state_e;

  fbwp_state_e            state_r;
  fbwp_pkg::fbwp_status_s status_r;
  fbwp_pkg::fbwp_result_s result_r;
  logic [1:0]             config_r;
  logic [ADDR_W-1:0]      addr_r;
  logic [7:0]             cmd_op_r;
  logic [7:0]             cmd_dat_r;
  logic                   cmd_pend_r;
  logic [31:0]            prdata_r;
  logic                   pready_r;
  logic                   pslverr_r;
  logic                   start_r;
  fbwp_pkg::fbwp_op_e     kind_r;
  logic [ADDR_W-1:0]      op_addr_r;
  logic                   vol_r;
  logic [7:0]             vol_op_r;
  logic                   quad_r;
  logic                   hold_r;
  logic                   wp_act_r;
  logic [1:0]             pin_meta_r;
  logic [1:0]             pin_sync_r;
  logic                   in_protected;
  fbwp_pkg::fbwp_op_e     cls;
  logic                   wr_done;
  logic                   rd_phase;
  logic                   pin_locked;

  // opcode classification, shared by the gate decision and the status byte update
  function automatic fbwp_pkg::fbwp_op_e op_class(input logic [7:0] opc);
    case (opc)
      `FBWP_OPC_WRITE_LATCH_SET_CMD:     op_class = fbwp_pkg::FBWP_OP_WRITE_LATCH_SET_CMD;
      `FBWP_OPC_WRDI:     op_class = fbwp_pkg::FBWP_OP_WRDI;
      `FBWP_OPC_STATUS_WRITE_CMD:     op_class = fbwp_pkg::FBWP_OP_STATUS_WRITE_CMD;
      `FBWP_OPC_PP,
      `FBWP_OPC_PP4,
      `FBWP_OPC_PPQ,
      `FBWP_OPC_PPQ4,
      `FBWP_OPC_PPQIO,
      `FBWP_OPC_PPQIO4:   op_class = fbwp_pkg::FBWP_OP_PROG;
      `FBWP_OPC_SE_A,
      `FBWP_OPC_SE_B,
      `FBWP_OPC_SE4,
      `FBWP_OPC_BE32,
      `FBWP_OPC_BE32_4,
      `FBWP_OPC_BE64,
      `FBWP_OPC_BE64_4:   op_class = fbwp_pkg::FBWP_OP_ERASE;
      `FBWP_OPC_CE_A,
      `FBWP_OPC_CE_B:     op_class = fbwp_pkg::FBWP_OP_CHIP;
      `FBWP_OPC_RDP_VOL,
      `FBWP_OPC_BANK_VOL: op_class = fbwp_pkg::FBWP_OP_VOL_FREE;
      `FBWP_OPC_RDP_VOLW,
      `FBWP_OPC_BANKVOLW: op_class = fbwp_pkg::FBWP_OP_VOL_WEL;
      default:            op_class = fbwp_pkg::FBWP_OP_NONE;
    endcase
  endfunction : op_class

  // the latch gates everything that changes non-volatile state
  function automatic logic needs_wel(input fbwp_pkg::fbwp_op_e c);
    case (c)
      fbwp_pkg::FBWP_OP_STATUS_WRITE_CMD,
      fbwp_pkg::FBWP_OP_PROG,
      fbwp_pkg::FBWP_OP_ERASE,
      fbwp_pkg::FBWP_OP_CHIP,
      fbwp_pkg::FBWP_OP_VOL_WEL: needs_wel = 1'b1;
      default:                   needs_wel = 1'b0;
    endcase
  endfunction : needs_wel

  assign cls      = op_class(cmd_op_r);
  assign wr_done  = psel & penable & pready_r & pwrite;
  assign rd_phase = psel & penable & ~pready_r;

  // pins from outside: two flops each, bit 0 protect, bit 1 hold
  for (genvar g = 0; g < 2; g++) begin : g_pin_sync
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        pin_meta_r[g] <= 1'b1;
        pin_sync_r[g] <= 1'b1;
      end else if (clk_en) begin
        pin_meta_r[g] <= (g == 0) ? wp_pin_n : hold_pin_n;
        pin_sync_r[g] <= pin_meta_r[g];
      end
    end
  end

  // in quad mode the protect pin is a data line and cannot lock anything
  assign pin_locked = status_r.status_write_disable & ~status_r.quad_enable & ~pin_sync_r[0];

  fbwp_prot_cmp #(
    .ADDR_W (ADDR_W)
  ) u_cmp (
    .addr              (addr_r),
    .level             (status_r.protect_level),
    .top_bottom_select (config_r[`FBWP_CFG_TBS]),
    .big_block         (config_r[`FBWP_CFG_BIG_BLK]),
    .in_protected      (in_protected)
  );

  // apb: one wait state so read data comes from a flop
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready_r  <= rd_phase;
      pslverr_r <= 1'b0;
      if (rd_phase) begin
        prdata_r <= 32'h0000_0000;
        case (paddr)
          `FBWP_OFF_STATUS: prdata_r <= {24'h00_0000, status_r};
          `FBWP_OFF_CONFIG: prdata_r <= {30'h0000_0000, config_r};
          `FBWP_OFF_ADDR:   prdata_r <= 32'(addr_r);
          `FBWP_OFF_CMD:    prdata_r <= {16'h0000, cmd_dat_r, cmd_op_r};
          `FBWP_OFF_RESULT: prdata_r <= {18'h0_0000, result_r};
          `FBWP_OFF_PINS:   prdata_r <= {27'h000_0000, wp_act_r, hold_r, quad_r, pin_sync_r};
          default:          pslverr_r <= 1'b1;
        endcase
        if (pwrite) begin
          prdata_r <= 32'h0000_0000;
          // status and result are read-only to the bus; status changes only by command
          pslverr_r <= !(paddr == `FBWP_OFF_CONFIG || paddr == `FBWP_OFF_ADDR ||
                         paddr == `FBWP_OFF_CMD);
        end
      end
    end
  end

  // configuration: bottom selection is one-time, it never returns to top
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      config_r <= `FBWP_CFG_RESET;
    end else if (clk_en && wr_done && paddr == `FBWP_OFF_CONFIG && pstrb[0]) begin
      config_r[`FBWP_CFG_TBS]     <= config_r[`FBWP_CFG_TBS] | pwdata[`FBWP_CFG_TBS];
      config_r[`FBWP_CFG_BIG_BLK] <= pwdata[`FBWP_CFG_BIG_BLK];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      addr_r <= '0;
    end else if (clk_en && wr_done && paddr == `FBWP_OFF_ADDR) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb[b] && b * 8 < ADDR_W) begin
          addr_r[b*8 +: 8] <= pwdata[b*8 +: 8];
        end
      end
    end
  end

  // command capture; a write to the command word launches it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_op_r   <= 8'h00;
      cmd_dat_r  <= 8'h00;
      cmd_pend_r <= 1'b0;
    end else if (clk_en) begin
      cmd_pend_r <= 1'b0;
      if (wr_done && paddr == `FBWP_OFF_CMD && pstrb[0]) begin
        cmd_op_r   <= pwdata[`FBWP_CMD_OP_LSB +: 8];
        cmd_dat_r  <= pstrb[1] ? pwdata[`FBWP_CMD_DAT_LSB +: 8] : cmd_dat_r;
        cmd_pend_r <= 1'b1;
      end
    end
  end

  // command sequencing
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= FBWP_ST_IDLE;
    end else if (clk_en) begin
      case (state_r)
        FBWP_ST_IDLE: begin
          if (cmd_pend_r) begin
            state_r <= FBWP_ST_EVAL;
          end
        end
        FBWP_ST_EVAL: begin
          state_r <= start_r ? FBWP_ST_BUSY : FBWP_ST_IDLE;
        end
        FBWP_ST_BUSY: begin
          if (array_op_done) begin
            state_r <= FBWP_ST_IDLE;
          end
        end
        default: state_r <= FBWP_ST_IDLE;
      endcase
    end
  end

  // gate decision, taken in idle with the registered command
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      result_r  <= '0;
      start_r   <= 1'b0;
      kind_r    <= fbwp_pkg::FBWP_OP_NONE;
      op_addr_r <= '0;
      vol_r     <= 1'b0;
      vol_op_r  <= 8'h00;
    end else if (clk_en) begin
      start_r <= 1'b0;
      vol_r   <= 1'b0;
      if (cmd_pend_r) begin
        result_r        <= '0;
        result_r.opcode <= cmd_op_r;
        if (state_r != FBWP_ST_IDLE) begin
          result_r.busy <= 1'b1;
        end else if (needs_wel(cls) && !status_r.write_enable_latch) begin
          result_r.no_wel <= 1'b1;
        end else begin
          case (cls)
            fbwp_pkg::FBWP_OP_PROG,
            fbwp_pkg::FBWP_OP_ERASE: begin
              if (in_protected) begin
                result_r.prot <= 1'b1;
              end else begin
                result_r.accept <= 1'b1;
                start_r         <= 1'b1;
                kind_r          <= cls;
                op_addr_r       <= addr_r;
              end
            end
            fbwp_pkg::FBWP_OP_CHIP: begin
              if (status_r.protect_level != 4'h0) begin
                result_r.chip_bp <= 1'b1;
              end else begin
                result_r.accept <= 1'b1;
                start_r         <= 1'b1;
                kind_r          <= cls;
                op_addr_r       <= '0;
              end
            end
            fbwp_pkg::FBWP_OP_STATUS_WRITE_CMD: begin
              result_r.status_lock <= pin_locked;
              result_r.accept      <= !pin_locked;
            end
            fbwp_pkg::FBWP_OP_VOL_FREE,
            fbwp_pkg::FBWP_OP_VOL_WEL: begin
              result_r.accept <= 1'b1;
              vol_r           <= 1'b1;
              vol_op_r        <= cmd_op_r;
            end
            fbwp_pkg::FBWP_OP_WRITE_LATCH_SET_CMD,
            fbwp_pkg::FBWP_OP_WRDI: begin
              result_r.accept <= 1'b1;
            end
            default: begin
              result_r.accept <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // status byte; non-volatile bits modelled as resettable flops
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_r <= `FBWP_SR_RESET;
    end else if (clk_en) begin
      status_r.busy <= (state_r == FBWP_ST_BUSY && !array_op_done) ||
                       (state_r == FBWP_ST_EVAL && start_r);
      if (state_r == FBWP_ST_BUSY && array_op_done) begin
        status_r.write_enable_latch <= 1'b0;
      end
      if (cmd_pend_r && state_r == FBWP_ST_IDLE) begin
        case (cls)
          fbwp_pkg::FBWP_OP_WRITE_LATCH_SET_CMD: status_r.write_enable_latch <= 1'b1;
          fbwp_pkg::FBWP_OP_WRDI: status_r.write_enable_latch <= 1'b0;
          fbwp_pkg::FBWP_OP_STATUS_WRITE_CMD: begin
            if (status_r.write_enable_latch && !pin_locked) begin
              status_r.status_write_disable <= cmd_dat_r[`FBWP_SR_SWD];
              status_r.quad_enable          <= cmd_dat_r[`FBWP_SR_QE];
              status_r.protect_level        <= {cmd_dat_r[`FBWP_SR_LVL3],
                                                cmd_dat_r[`FBWP_SR_LVL_HI],
                                                cmd_dat_r[`FBWP_SR_LVL_MID],
                                                cmd_dat_r[`FBWP_SR_LVL_LO]};
              status_r.write_enable_latch   <= 1'b0;
            end
          end
          fbwp_pkg::FBWP_OP_VOL_WEL: begin
            if (status_r.write_enable_latch) begin
              status_r.write_enable_latch <= 1'b0;
            end
          end
          default: status_r.write_enable_latch <= status_r.write_enable_latch;
        endcase
      end
    end
  end

  // pin function follows quad-enable
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      quad_r   <= 1'b0;
      hold_r   <= 1'b0;
      wp_act_r <= 1'b0;
    end else if (clk_en) begin
      quad_r   <= status_r.quad_enable;
      hold_r   <= ~status_r.quad_enable & ~pin_sync_r[1];
      wp_act_r <= ~status_r.quad_enable & ~pin_sync_r[0];
    end
  end

  assign prdata               = prdata_r;
  assign pready               = pready_r;
  assign pslverr              = pslverr_r;
  assign array_op_start       = start_r;
  assign array_op_kind        = kind_r;
  assign array_op_addr        = op_addr_r;
  assign vol_cmd_strobe       = vol_r;
  assign vol_cmd_opcode       = vol_op_r;
  assign quad_mode            = quad_r;
  assign hold_active          = hold_r;
  assign write_protect_active = wp_act_r;

endmodule : fbwp_top
`default_nettype wire

// ### tb.sv
// self-checking bench for fbwp_top
// assumes package, checker and array model compiled first
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic wp_pin_n, hold_pin_n, done, start, vstb, quad, hact, wpact;
  logic [7:0] paddr, vop;
  logic [31:0] pwdata, prdata, aaddr, rd, res;
  fbwp_pkg::fbwp_op_e kind;
  int fails = 0, num_checks = 0, nst = 0, nvol = 0;
  fbwp_top DUT (.sys_clk, .rst, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hf), .prdata, .pready, .pslverr, .wp_pin_n, .hold_pin_n, .array_op_done(done),
    .array_op_start(start), .array_op_kind(kind), .array_op_addr(aaddr), .vol_cmd_strobe(vstb),
    .vol_cmd_opcode(vop), .quad_mode(quad), .hold_active(hact), .write_protect_active(wpact));
  fbwp_array_model u_eng (.sys_clk, .rst, .array_op_start(start), .array_op_done(done));
  always @(posedge sys_clk) begin
    if (start === 1'b1) nst++;
    if (vstb === 1'b1) nvol++;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // wait until pready rises; the watchdog ends the run if it never does
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // launch, fetch result, then wait out any array operation
  task automatic cmd(input logic [7:0] op, input logic [7:0] dat);
    apb(1'b1, 8'h0c, {16'h0, dat, op});
    apb(1'b0, 8'h10, 32'h0);
    res = rd;
    do apb(1'b0, 8'h00, 32'h0); while (rd[0] !== 1'b0);
  endtask : cmd
  task automatic status_wr(input logic [7:0] v);
    cmd(8'h06, 8'h00);
    cmd(8'h01, v);
  endtask : status_wr
  function automatic int pcnt(input int l, input logic big);
    if (l == 0) return 0;
    if (big) return l > 8 ? 256 : 1 << (l - 1);
    if (l <= 10) return 1 << (l - 1);
    return l == 15 ? 1024 : l == 11 ? 768 : l == 12 ? 896 : l == 13 ? 960 : 992;
  endfunction : pcnt
  task automatic t_reset;
    apb(1'b0, 8'h00, 32'h0);
    chk("status", rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", {rd[30:0], er}, 32'h1);
  endtask : t_reset
  task automatic t_latch;
    int s, v;
    s = nst;
    cmd(8'hd8, 8'h00);
    chk("no_latch", res[1:0], 32'h2);
    for (int i = 0; i < 2; i++) begin
      v = nvol;
      cmd(i ? 8'h17 : 8'hc0, 8'h00);
      chk("vol_acc", {res[0], vop}, {1'b1, i ? 8'h17 : 8'hc0});
      chk("vol_stb", nvol - v, 32'h1);
    end
    cmd(8'h06, 8'h00);
    chk("write_latch_set_cmd", rd[1], 1'b1);
    cmd(8'h63, 8'h00);
    chk("vol_wel", {res[0], vop, rd[1]}, {1'b1, 8'h63, 1'b0});
    cmd(8'h06, 8'h00);
    cmd(8'h04, 8'h00);
    cmd(8'hc5, 8'h00);
    chk("wrdi", {rd[1], res[1:0]}, 32'h2);
    chk("no_start", nst - s, 32'h0);
  endtask : t_latch
  task automatic t_lock;
    status_wr(8'h80);
    chk("swd", rd, 32'h80);
    wp_pin_n <= 1'b0;
    status_wr(8'h04);
    chk("locked", res[5], 32'h1);
    chk("kept", rd, 32'h82);
    wp_pin_n <= 1'b1;
    status_wr(8'h44);
    chk("unlocked", rd, 32'h44);
    chk("quad", {quad, wpact}, 32'h2);
    wp_pin_n <= 1'b0;
    hold_pin_n <= 1'b0;
    status_wr(8'h08);
    chk("open", rd, 32'h08);
    chk("pins", {quad, hact, wpact}, 32'h3);
    wp_pin_n <= 1'b1;
    hold_pin_n <= 1'b1;
  endtask : t_lock
  task automatic try_blk(input int b, input logic big, input logic p);
    int s;
    s = nst;
    cmd(8'h06, 8'h00);
    apb(1'b1, 8'h08, big ? b << 18 : b << 16);
    cmd(8'hd8, 8'h00);
    chk("prot", res[2], p);
    chk("start", nst - s, !p);
    if (!p) chk("erase_addr", aaddr, big ? b << 18 : b << 16);
  endtask : try_blk
  task automatic t_prot(input logic big, input logic bot);
    int c, n;
    apb(1'b1, 8'h04, {30'h0, big, bot});
    for (int l = 0; l < 16; l++) begin
      c = pcnt(l, big);
      n = big ? 256 : 1024;
      status_wr(8'(l << 2));
      if (c > 0) try_blk(bot ? c - 1 : n - c, big, 1'b1);
      if (c < n) try_blk(bot ? c : n - c - 1, big, 1'b0);
    end
  endtask : t_prot
  task automatic t_chip;
    int s;
    s = nst;
    cmd(8'h06, 8'h00);
    cmd(8'hc7, 8'h00);
    chk("chip_bp", {res[3], 8'(nst - s)}, 32'h100);
    status_wr(8'h00);
    cmd(8'h06, 8'h00);
    cmd(8'h60, 8'h00);
    chk("chip", {res[0], kind, 8'(nst - s)}, {1'b1, fbwp_pkg::FBWP_OP_CHIP, 8'h01});
    chk("chip_addr", aaddr, 32'h0);
  endtask : t_chip
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    #80000;
    fails++;
    conclude();
  end
  initial begin
    {rst, wp_pin_n, hold_pin_n} = 3'h7;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_latch();
    t_lock();
    t_prot(1'b0, 1'b0);
    t_prot(1'b1, 1'b1);
    t_chip();
    conclude();
  end
endmodule : tb
`default_nettype wire
